//--- lut_map_pkg.sv
package lut_map_pkg;
  localparam int COMP_W = 8;
  localparam int DEPTH = 1 << COMP_W;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 16;
  localparam int DIM_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 16'h0000;
  localparam logic [ADDR_W-1:0] OFF_GIE = 16'h0004;
  localparam logic [ADDR_W-1:0] OFF_IER = 16'h0008;
  localparam logic [ADDR_W-1:0] OFF_ISR = 16'h000c;
  localparam logic [ADDR_W-1:0] OFF_WIDTH = 16'h0010;
  localparam logic [ADDR_W-1:0] OFF_HEIGHT = 16'h0018;
  localparam logic [ADDR_W-1:0] OFF_FORMAT = 16'h0020;
  localparam logic [ADDR_W-1:0] OFF_TABLE0 = 16'h0800;
  localparam logic [ADDR_W-1:0] OFF_TABLE1 = 16'h0a00;
  localparam logic [ADDR_W-1:0] OFF_TABLE2 = 16'h0c00;
  localparam logic [ADDR_W-1:0] TABLE_SPAN = 16'h0200;
  localparam int BIT_GO = 0;
  localparam int BIT_DONE = 1;
  localparam int BIT_QUIET = 2;
  localparam int BIT_ACCEPTS = 3;
  localparam int BIT_AUTO = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] FMT_RGB = 2'h0;
  localparam logic [1:0] FMT_YUV = 2'h1;
  localparam int RESET_HOLD_CYCLES = 16;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_FINISH = 3'b100
  } run_state_t;
endpackage

//--- lut_map.sv
`timescale 1ns/1ns
`default_nettype none
module lut_map (
  // Clock and synchronous active-low reset
  input wire logic clk,
  input wire logic core_reset_low,
  // Register write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lut_map_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Register read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [lut_map_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Input video stream
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic [lut_map_pkg::DATA_W-1:0] s_axis_tdata,
  input wire logic s_axis_tuser,
  input wire logic s_axis_tlast,
  // Output video stream
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  output logic [lut_map_pkg::DATA_W-1:0] m_axis_tdata,
  output logic m_axis_tuser,
  output logic m_axis_tlast
);
  import lut_map_pkg::*;

  // One clock drives everything; reset is sampled on it.
  wire logic rst_n = core_reset_low;

  logic [COMP_W-1:0] table_mem [3][DEPTH];
  logic go, done, auto_run, gie;
  logic [1:0] ier, isr;
  logic [DIM_W-1:0] width, height;
  logic [1:0] fmt;
  run_state_t state;
  logic [DIM_W-1:0] col, row;
  logic aw_hold, w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire logic do_write = aw_hold && w_hold && !s_axi_bvalid;
  wire logic do_read = s_axi_arvalid && s_axi_arready;
  wire logic handshake = (state == ST_IDLE) && (go || auto_run);
  wire logic frame_end = (state == ST_FINISH);
  wire logic in_fire = s_axis_tvalid && s_axis_tready;
  wire logic last_pix = (col == width - 16'd1) && (row == height - 16'd1);

  function automatic logic in_table(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    in_table = (a >= b) && (a < b + TABLE_SPAN);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFF_CONTROL) || (a == OFF_GIE) || (a == OFF_IER) || (a == OFF_ISR)
      || (a == OFF_WIDTH) || (a == OFF_HEIGHT) || (a == OFF_FORMAT)
      || in_table(a, OFF_TABLE0) || in_table(a, OFF_TABLE1) || in_table(a, OFF_TABLE2);
  endfunction

  // Write address and data are collected independently, then applied together.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready;
      s_axi_wready <= !w_hold && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; there is no soft reset bit anywhere in the map.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_run <= 1'b0;
      gie <= 1'b0;
      ier <= '0;
      width <= '0;
      height <= '0;
      fmt <= '0;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        OFF_CONTROL: auto_run <= w_data[BIT_AUTO];
        OFF_GIE: gie <= w_data[0];
        OFF_IER: ier <= w_data[1:0];
        OFF_WIDTH: width <= w_data[DIM_W-1:0];
        OFF_HEIGHT: height <= w_data[DIM_W-1:0];
        OFF_FORMAT: fmt <= w_data[1:0];
        default: ;
      endcase
      if (aw_addr == OFF_WIDTH || aw_addr == OFF_HEIGHT) begin
        if (w_strb[1]) begin
          if (aw_addr == OFF_WIDTH) width[DIM_W-1:8] <= w_data[DIM_W-1:8];
          else height[DIM_W-1:8] <= w_data[DIM_W-1:8];
        end
      end
    end
  end

  // Three tables, one per component, loaded two entries to a word.
  for (genvar t = 0; t < 3; t++) begin : g_table
    localparam logic [ADDR_W-1:0] BASE = OFF_TABLE0 + ADDR_W'(t) * TABLE_SPAN;
    wire logic hit = do_write && in_table(aw_addr, BASE);
    wire logic [COMP_W-1:0] idx = COMP_W'({(aw_addr - BASE) >> 2, 1'b0});
    always_ff @(posedge clk) begin
      if (hit && w_strb[0]) table_mem[t][idx] <= w_data[COMP_W-1:0];
      if (hit && w_strb[2]) table_mem[t][idx | 8'h01] <= w_data[16+COMP_W-1:16];
    end
  end

  // Start, done and interrupt status; a new event wins over a read clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      go <= 1'b0;
      done <= 1'b0;
      isr <= '0;
    end else begin
      if (do_write && w_strb[0] && aw_addr == OFF_CONTROL && w_data[BIT_GO]) go <= 1'b1;
      else if (handshake) go <= 1'b0;
      if (frame_end) done <= 1'b1;
      else if (do_read && s_axi_araddr == OFF_CONTROL) done <= 1'b0;
      isr <= {handshake, frame_end};
    end
  end

  // Frame sequencer counts pixels and lines so each frame ends on time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      col <= '0;
      row <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          col <= '0;
          row <= '0;
          if (handshake) state <= ST_RUN;
        end
        ST_RUN: begin
          if (in_fire) begin
            if (last_pix) state <= ST_FINISH;
            else if (col == width - 16'd1) begin
              col <= '0;
              row <= row + 16'd1;
            end else begin
              col <= col + 16'd1;
            end
          end
        end
        ST_FINISH: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Register reads; the answer is held until taken.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= REG_RESET;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          OFF_CONTROL: s_axi_rdata <= {24'h0, auto_run, 3'h0, (state == ST_IDLE),
            (state == ST_IDLE), done, go};
          OFF_GIE: s_axi_rdata <= {31'h0, gie};
          OFF_IER: s_axi_rdata <= {30'h0, ier};
          OFF_ISR: s_axi_rdata <= {30'h0, isr};
          OFF_WIDTH: s_axi_rdata <= {16'h0, width};
          OFF_HEIGHT: s_axi_rdata <= {16'h0, height};
          OFF_FORMAT: s_axi_rdata <= {30'h0, fmt};
          default: begin
            // Table words read back two entries at a time, upper byte of each half zero.
            if (in_table(s_axi_araddr, OFF_TABLE0) || in_table(s_axi_araddr, OFF_TABLE1)
                || in_table(s_axi_araddr, OFF_TABLE2)) begin
              s_axi_rdata <= {8'h00, table_mem[s_axi_araddr[10:9]][{s_axi_araddr[8:2], 1'b1}],
                8'h00, table_mem[s_axi_araddr[10:9]][{s_axi_araddr[8:2], 1'b0}]};
            end else begin
              s_axi_rdata <= REG_RESET;
            end
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // One-stage skid-free pipe: input ready only when the output slot is free or drains.
  logic in_fire_last, slot_next;
  always_comb in_fire_last = in_fire && last_pix;
  // Ready is registered and the sink may stall at any time, so input is offered only when
  // the output slot is certain to be empty next cycle; this halves peak throughput.
  always_comb slot_next = !(m_axis_tvalid && !m_axis_tready) && !in_fire;
  always_ff @(posedge clk) begin
    if (!rst_n) s_axis_tready <= 1'b0;
    else s_axis_tready <= (state == ST_RUN) && !in_fire_last && slot_next;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      m_axis_tvalid <= 1'b0;
      m_axis_tdata <= '0;
      m_axis_tuser <= 1'b0;
      m_axis_tlast <= 1'b0;
    end else if (in_fire) begin
      m_axis_tvalid <= 1'b1;
      // Table reads use the current contents, so new tables show at once.
      for (int c = 0; c < 3; c++) begin
        m_axis_tdata[c*COMP_W +: COMP_W] <= table_mem[c][s_axis_tdata[c*COMP_W +: COMP_W]];
      end
      m_axis_tuser <= s_axis_tuser;
      m_axis_tlast <= s_axis_tlast;
    end else if (m_axis_tready) begin
      m_axis_tvalid <= 1'b0;
    end
  end

  a_hold_output: assert property (@(posedge clk) disable iff (!rst_n)
    m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid && $stable(m_axis_tdata))
    else $error("output changed while stalled");
  a_go_clears: assert property (@(posedge clk) disable iff (!rst_n)
    handshake |=> !go || auto_run || $past(do_write))
    else $error("start bit did not clear");
  a_done_set: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end |=> done && state == ST_IDLE)
    else $error("done not raised");
  a_run_start: assert property (@(posedge clk) disable iff (!rst_n)
    handshake |=> state == ST_RUN)
    else $error("frame did not start");
  a_auto_run: assert property (@(posedge clk) disable iff (!rst_n)
    auto_run && state == ST_FINISH |=> ##1 state == ST_RUN)
    else $error("free run did not restart");
  a_user_pass: assert property (@(posedge clk) disable iff (!rst_n)
    in_fire |=> m_axis_tuser == $past(s_axis_tuser) && m_axis_tlast == $past(s_axis_tlast))
    else $error("sideband not passed");
  a_no_input_idle: assert property (@(posedge clk) disable iff (!rst_n)
    state != ST_RUN |-> !in_fire)
    else $error("pixel taken outside frame");
  a_isr_done: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end |=> isr[0])
    else $error("status missed done");
endmodule
`default_nettype wire

//--- video_partner.sv
`timescale 1ns/1ns
`default_nettype none
module video_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic core_reset_low,
  // Frame size agreed with software
  input wire logic [15:0] width,
  input wire logic [15:0] height,
  // Stream toward the core
  output logic src_valid,
  input wire logic src_ready,
  output logic [23:0] src_data,
  output logic src_first,
  output logic src_eol,
  // Stream from the core
  output logic snk_ready
);
  logic [31:0] pix;
  logic [15:0] col;
  logic [3:0] tick;
  always_ff @(posedge clk) begin
    if (!core_reset_low) begin
      pix <= '0;
      col <= '0;
      tick <= '0;
      src_valid <= 1'b0;
    end else begin
      tick <= tick + 4'h1;
      if (src_valid && src_ready) begin
        pix <= (pix == 32'(width) * 32'(height) - 1) ? '0 : pix + 1;
        col <= (col == width - 1) ? '0 : col + 16'h1;
      end
      // An offered pixel is never withdrawn; gaps appear only between transfers.
      if (!src_valid || src_ready) begin
        src_valid <= (tick != 4'h6);
      end
    end
  end
  // Data is a function of the pixel index, so it holds while a transfer waits.
  assign src_data = {pix[7:0] + 8'h33, ~pix[7:0], pix[7:0]};
  assign src_first = (pix == 32'h0);
  assign src_eol = (col == width - 1);
  // The sink stalls one cycle in four to exercise output backpressure.
  assign snk_ready = (tick[1:0] != 2'h2);
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb_top;
  import lut_map_pkg::*;
  localparam int W = 64;
  localparam int H = 64;
  logic clk = 0, core_reset_low = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic bready = 1, rready = 1;
  logic [15:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid, s_tvalid, s_tready, s_tuser, s_tlast;
  logic m_tvalid, m_tready, m_tuser, m_tlast;
  logic [1:0] bresp, rresp;
  logic [23:0] s_tdata, m_tdata;
  logic [15:0] zr [7] = '{OFF_GIE, OFF_IER, OFF_ISR, OFF_WIDTH, OFF_HEIGHT, OFF_FORMAT, OFF_TABLE0};
  int failures = 0, samples_checked = 0, frames = 0, q = 0, gen = 0;
  initial forever #4 clk = ~clk;
  lut_map i_lut_map (.clk(clk), .core_reset_low(core_reset_low),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axis_tvalid(s_tvalid), .s_axis_tready(s_tready), .s_axis_tdata(s_tdata),
    .s_axis_tuser(s_tuser), .s_axis_tlast(s_tlast), .m_axis_tvalid(m_tvalid),
    .m_axis_tready(m_tready), .m_axis_tdata(m_tdata), .m_axis_tuser(m_tuser),
    .m_axis_tlast(m_tlast));
  video_partner i_video_partner (.clk(clk), .core_reset_low(core_reset_low),
    .width(16'(W)), .height(16'(H)), .src_valid(s_tvalid), .src_ready(s_tready),
    .src_data(s_tdata), .src_first(s_tuser), .src_eol(s_tlast), .snk_ready(m_tready));
  function automatic logic [7:0] tab(input int k, input logic [7:0] v);
    return (v ^ 8'(90 * k + 15 * gen)) + 8'(k);
  endfunction
  task automatic wrap_up();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stuck(input int k);
    if (k >= 50) begin
      failures++;
      $display("Error bus expected answer seen none");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic ta, td;
    k = 0;
    ta = 0;
    td = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ta && td) && k < 50) begin
      @(posedge clk);
      k++;
      if (!ta && awready) begin ta = 1; awvalid <= 0; end
      if (!td && wready) begin td = 1; wvalid <= 0; end
    end
    do begin @(posedge clk); k++; end while (!bvalid && k < 50);
    stuck(k);
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1;
    do begin @(posedge clk); k++; end while (!arready && k < 50);
    arvalid <= 0;
    do begin @(posedge clk); k++; end while (!rvalid && k < 50);
    stuck(k);
    `CHK("rdata", e, rdata & m)
    `CHK("rresp", er, rresp)
  endtask
  task automatic load();
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; n < DEPTH / 2; n++) begin
        wr(OFF_TABLE0 + 16'(k) * TABLE_SPAN + 16'(4 * n),
           {8'h00, tab(k, 8'(2 * n + 1)), 8'h00, tab(k, 8'(2 * n))}, RESP_OKAY);
      end
    end
  endtask
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (frames < n && k < 30000) begin @(posedge clk); k++; end
    if (frames < n) begin
      failures++;
      $display("Error frames expected %0d seen %0d", n, frames);
      wrap_up();
    end
  endtask
  // Every accepted output pixel is checked against the tables in force.
  always @(posedge clk) if (core_reset_low && m_tvalid && m_tready) begin : mon
    logic [7:0] v;
    v = q[7:0];
    `CHK("pixel", {tab(2, v + 8'h33), tab(1, ~v), tab(0, v)}, m_tdata)
    `CHK("first", (q == 0), m_tuser)
    `CHK("eol", ((q % W) == W - 1), m_tlast)
    q = (q == W * H - 1) ? 0 : q + 1;
    if (q == 0) frames++;
  end
  initial begin
    repeat (16) @(posedge clk);
    core_reset_low <= 1;
    repeat (2) @(posedge clk);
    rd(OFF_CONTROL, 32'h0000_000c, 32'h0000_008f, RESP_OKAY);
    foreach (zr[i]) rd(zr[i], 32'h0, 32'hffff_ffff, RESP_OKAY);
    wr(OFF_GIE, 32'h1, RESP_OKAY);
    rd(OFF_GIE, 32'h1, 32'hffff_ffff, RESP_OKAY);
    wr(OFF_IER, 32'h3, RESP_OKAY);
    rd(OFF_IER, 32'h3, 32'hffff_ffff, RESP_OKAY);
    wr(16'h0100, 32'h5, RESP_SLVERR);
    rd(16'h0100, 32'h0, 32'hffff_ffff, RESP_SLVERR);
    wr(OFF_WIDTH, 32'(W), RESP_OKAY);
    wr(OFF_HEIGHT, 32'(H), RESP_OKAY);
    rd(OFF_WIDTH, 32'(W), 32'hffff_ffff, RESP_OKAY);
    rd(OFF_HEIGHT, 32'(H), 32'hffff_ffff, RESP_OKAY);
    wr(OFF_FORMAT, 32'(FMT_YUV), RESP_OKAY);
    rd(OFF_FORMAT, 32'(FMT_YUV), 32'hffff_ffff, RESP_OKAY);
    load();
    rd(OFF_TABLE0 + 16'h14, {8'h00, tab(0, 8'h0b), 8'h00, tab(0, 8'h0a)}, 32'h00ff_00ff,
       RESP_OKAY);
    wr(OFF_CONTROL, 32'h1, RESP_OKAY);
    rd(OFF_CONTROL, 32'h0, 32'h0000_0004, RESP_OKAY);
    wait_frames(1);
    repeat (4) @(posedge clk);
    rd(OFF_CONTROL, 32'h0000_000e, 32'h0000_000f, RESP_OKAY);
    rd(OFF_CONTROL, 32'h0000_000c, 32'h0000_000f, RESP_OKAY);
    // New tables between frames must take effect on the next frame; the format register does not change the output.
    gen = 1;
    load();
    wr(OFF_FORMAT, 32'(FMT_RGB), RESP_OKAY);
    wr(OFF_CONTROL, 32'h81, RESP_OKAY);
    rd(OFF_CONTROL, 32'h80, 32'h0000_0080, RESP_OKAY);
    wait_frames(3);
    wr(OFF_CONTROL, 32'h0, RESP_OKAY);
    wait_frames(4);
    repeat (300) @(posedge clk);
    `CHK("frames", 4, frames)
    `CHK("tail", 0, q)
    wrap_up();
  end
endmodule
`default_nettype wire
